// ===== hw/sysreg_defines.svh
// Purpose: offsets, field positions and reset values of the system register group
// Assumes: byte-wide register file addressing, registers at their printed numbers
// Notes: definitions only
`ifndef SYSREG_DEFINES_SVH
`define SYSREG_DEFINES_SVH

// ****************************************
// Register offsets
// ****************************************
`define OFS_FIRST_PTR 8'he8
`define OFS_SECOND_PTR 8'he9
`define OFS_PAGE_SELECT 8'hea
`define OFS_CORE_MODE 8'heb
`define OFS_USER_SP_HI 8'hec
`define OFS_USER_SP_LO 8'hed
`define OFS_SYS_SP_HI 8'hee
`define OFS_SYS_SP_LO 8'hef

// ****************************************
// Field positions
// ****************************************
`define PTR_BLOCK_MSB 7
`define PTR_BLOCK_LSB 3
`define PTR_MODE_BIT 2
`define PAGE_MSB 7
`define PAGE_LSB 2
`define MODE_SYS_STACK_BIT 7
`define MODE_USER_STACK_BIT 6
`define MODE_HALVE_BIT 5
`define MODE_PRESCALE_MSB 4
`define MODE_PRESCALE_LSB 2
`define MODE_BUS_REQ_BIT 1
`define MODE_FLOAT_BIT 0

// ****************************************
// Reset values
// ****************************************
`define CORE_MODE_RESET 8'he0
`define BLOCK_RESET 5'h00
`define PAGE_RESET 6'h00
`define SP_RESET 16'h0000

`endif

// ===== hw/sysreg_pkg.sv
// Purpose: shared types of the system register logic
// Assumes: constants live in sysreg_defines.svh
// Notes: types only
package sysreg_pkg;
	typedef enum logic {ST_IDLE, ST_PUSH} push_state_t;
	typedef logic [15:0] sp_word_t;
	typedef logic [7:0] reg_byte_t;
endpackage

// ===== hw/stack_ptr_if.sv
// Purpose: carries step and load requests to one stack pointer
// Assumes: one controller, one pointer unit
// Notes: ptr is the live pointer value
`timescale 1ns/1ps
interface stack_ptr_if;
	logic step_down;
	logic step_up;
	logic step_two;
	logic internal;
	logic load_hi;
	logic load_lo;
	logic [7:0] load_data;
	logic [15:0] ptr;
	modport ctrl (output step_down, step_up, step_two, internal, load_hi, load_lo, load_data,
		input ptr);
	modport unit (input step_down, step_up, step_two, internal, load_hi, load_lo, load_data,
		output ptr);
endinterface

// ===== hw/stack_pointer_unit.sv
// Purpose: one double-byte stack pointer with pre-decrement and post-increment
// Assumes: a step and a load never matter in the same cycle; the step wins
// Notes: in register-file mode only the low byte moves
`timescale 1ns/1ps
module stack_pointer_unit
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Controller side
	stack_ptr_if.unit sp
);
	import sysreg_pkg::*;
	`include "sysreg_defines.svh"

	sp_word_t ptr_reg;
	sp_word_t ptr_next;
	sp_word_t sum;

	// ****************************************
	// Next pointer value
	// ****************************************
	// High byte is held in register-file mode so a wrap cannot leak into it
	always_comb
	begin
		sum = ptr_reg;
		if (sp.step_down)
			sum = ptr_reg - 16'h0001;
		else if (sp.step_up)
			sum = ptr_reg + (sp.step_two ? 16'h0002 : 16'h0001);
		ptr_next = sp.internal ? {ptr_reg[15:8], sum[7:0]} : sum; // RULE22
		if (!sp.step_down && !sp.step_up)
		begin
			if (sp.load_hi)
				ptr_next[15:8] = sp.load_data;
			if (sp.load_lo)
				ptr_next[7:0] = sp.load_data;
		end
	end

	// Pointer register
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			ptr_reg <= `SP_RESET;
		else
			ptr_reg <= ptr_next; // RULE18
	end

	assign sp.ptr = ptr_reg;
endmodule

// ===== hw/internal_clock_divider.sv
// Purpose: internal clock tick from the oscillator input
// Assumes: i_clk is the oscillator input
// Notes: factor is (prescale + 1) times 1 or 2
`timescale 1ns/1ps
module internal_clock_divider
#(
	parameter int PRESCALE_W = 3
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Division setting
	input wire logic i_halve,
	input wire logic [PRESCALE_W-1:0] i_prescale,
	// Tick out
	output logic o_tick
);
	logic [PRESCALE_W:0] cnt_reg;
	logic [PRESCALE_W:0] limit;

	// Terminal count; >= lets a smaller factor take effect at once
	always_comb
	begin
		limit = i_halve ? {i_prescale, 1'b1} : {1'b0, i_prescale}; // RULE12 RULE13
	end

	// Counter and tick
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cnt_reg <= '0;
			o_tick <= 1'b0;
		end
		else if (cnt_reg >= limit)
		begin
			cnt_reg <= '0;
			o_tick <= 1'b1;
		end
		else
		begin
			cnt_reg <= cnt_reg + 1'b1;
			o_tick <= 1'b0;
		end
	end
endmodule

// ===== hw/sysreg_core.sv
// Purpose: register pointers, page select, mode register and stack pointers of the core
// Assumes: one CPU clock, instruction strobes are one-cycle pulses from the sequencer
// Notes: reads answer one cycle after the strobe
//
// Operation
// RULE1: single-pointer instruction clears mode bit; set-first/second-pointer instructions set it.
// RULE2: Pointer register bits 1:0 always read zero.
// RULE3: In twin mode second pointer block supplies working registers r8 to r15.
// RULE4: Software keeps second pointer reserved when it is not in twin use.
// RULE5: Up to 64 pages of 16 registers map into the top group.
// RULE6: Page number bits 7:2 hold set-page operand until rewritten.
// RULE7: Page select bits 1:0 always read zero.
// RULE8: Interrupt entry never pushes the page select register.
// RULE9: Mode register resets to e0.
// RULE10: Mode bit 7 places system stack in register file when set.
// RULE11: Mode bit 6 places user stack in register file when set.
// RULE12: Mode bit 5 halves the oscillator input clock.
// RULE13: Mode bits 4:2 set internal clock division from 1 to 8.
// RULE14: Mode bit 1 enables bus requests from the request pin.
// RULE15: Mode bit 0 floats external address, data, strobe and direction lines.
// RULE16: Float control leaves lines used as general I/O untouched.
// RULE17: Software should set float control when only internal memory is used.
// RULE18: Stack pointer pre-decrements on push, post-increments on pop, by byte or word.
// RULE19: Pop only moves the pointer; stack contents stay unchanged.
// RULE20: Interrupt entry pushes PC, flags and code segment if enabled.
// RULE21: Near call pushes PC; segment call pushes PC and code segment.
// RULE22: Register-file stacks use only the pointer low byte.
// RULE23: Register file is seen as 32 blocks of eight registers.
// RULE24: Single mode group starts at even block at or below the given one.
// RULE25: Working address from first pointer, or pointer chosen by index bit 3.
`timescale 1ns/1ps
module sysreg_core
#(
	parameter int EXT_LINES = 16,
	parameter int CTRL_LINES = 3
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Register file access
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire sysreg_pkg::reg_byte_t i_reg_wdata,
	output sysreg_pkg::reg_byte_t o_reg_rdata,
	output logic o_reg_ack,
	// Pointer instructions
	input wire logic i_set_single,
	input wire logic i_set_first_pointer,
	input wire logic i_set_second_pointer,
	input wire logic i_set_page,
	input wire logic [7:0] i_instr_operand,
	// Working register translation
	input wire logic [3:0] i_work_index,
	output logic [7:0] o_work_addr,
	output logic [5:0] o_page_number,
	// Software stack operations
	input wire logic i_push,
	input wire logic i_push_word,
	input wire sysreg_pkg::sp_word_t i_push_data,
	input wire logic i_pop,
	input wire logic i_pop_word,
	input wire logic i_stack_user,
	// Automatic pushes
	input wire logic i_interrupt_entry,
	input wire logic i_call_near,
	input wire logic i_call_segment,
	input wire sysreg_pkg::sp_word_t i_pc,
	input wire logic [7:0] i_flags,
	input wire logic [5:0] i_code_segment,
	input wire logic i_segment_push_enable,
	// Stack memory port
	output logic o_stack_wr,
	output logic o_stack_rd,
	output sysreg_pkg::sp_word_t o_stack_addr,
	output sysreg_pkg::reg_byte_t o_stack_wdata,
	output logic o_stack_in_regfile,
	output logic o_stack_busy,
	// Mode outputs
	output logic o_system_stack_internal,
	output logic o_user_stack_internal,
	output logic o_internal_clock_tick,
	// External bus
	input wire logic i_bus_request_pin,
	output logic o_bus_request,
	input wire logic [EXT_LINES-1:0] i_ext_addr_oe,
	input wire logic [EXT_LINES-1:0] i_ext_is_bus,
	input wire logic [CTRL_LINES-1:0] i_ext_ctrl_oe,
	output logic [EXT_LINES-1:0] o_ext_addr_oe,
	output logic [CTRL_LINES-1:0] o_ext_ctrl_oe,
	output logic o_bus_float
);
	import sysreg_pkg::*;
	`include "sysreg_defines.svh"

	// ****************************************
	// Declarations
	// ****************************************
	logic [4:0] first_block_reg;
	logic [4:0] second_block_reg;
	logic pointer_mode_reg;
	logic [5:0] page_reg;
	reg_byte_t mode_reg;
	logic bus_request_pin_meta_reg;
	logic bus_request_pin_sync_reg;
	push_state_t state_reg;
	logic [31:0] queue_reg;
	logic [2:0] count_reg;
	logic target_user_reg;
	logic wr_first;
	logic wr_second;
	logic wr_page;
	logic wr_mode;
	logic auto_any;
	logic auto_go;
	logic push_go;
	logic pop_go;
	logic push_step;
	logic push_user;
	logic sys_internal;
	logic user_internal;
	sp_word_t sys_dec;
	sp_word_t user_dec;
	sp_word_t push_addr;
	sp_word_t pop_addr;
	reg_byte_t read_mux;
	logic read_hit;

	stack_ptr_if sys_ptr ();
	stack_ptr_if user_ptr ();

	// ****************************************
	// Register write decode
	// ****************************************
	assign wr_first = i_reg_wr && (i_reg_addr == `OFS_FIRST_PTR);
	assign wr_second = i_reg_wr && (i_reg_addr == `OFS_SECOND_PTR);
	assign wr_page = i_reg_wr && (i_reg_addr == `OFS_PAGE_SELECT);
	assign wr_mode = i_reg_wr && (i_reg_addr == `OFS_CORE_MODE);

	// ****************************************
	// Working register pointers
	// ****************************************
	// First block; an instruction beats a same-cycle register write
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			first_block_reg <= `BLOCK_RESET;
		else if (i_set_single || i_set_first_pointer)
			first_block_reg <= i_instr_operand[4:0]; // RULE23
		else if (wr_first)
			first_block_reg <= i_reg_wdata[`PTR_BLOCK_MSB:`PTR_BLOCK_LSB];
	end

	// Second block, only meaningful in twin mode
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			second_block_reg <= `BLOCK_RESET;
		else if (i_set_second_pointer)
			second_block_reg <= i_instr_operand[4:0]; // RULE3
		else if (wr_second)
			second_block_reg <= i_reg_wdata[`PTR_BLOCK_MSB:`PTR_BLOCK_LSB];
	end

	// Mode bit shared by both pointer registers
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			pointer_mode_reg <= 1'b0;
		else if (i_set_single)
			pointer_mode_reg <= 1'b0; // RULE1
		else if (i_set_first_pointer || i_set_second_pointer)
			pointer_mode_reg <= 1'b1; // RULE1
		else if (wr_first || wr_second)
			pointer_mode_reg <= i_reg_wdata[`PTR_MODE_BIT];
	end

	// Working address; odd blocks round down in single mode
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_work_addr <= 8'h00;
		else if (!pointer_mode_reg)
			o_work_addr <= {first_block_reg[4:1], i_work_index}; // RULE24 RULE25
		else if (i_work_index[3])
			o_work_addr <= {second_block_reg, i_work_index[2:0]}; // RULE3 RULE25
		else
			o_work_addr <= {first_block_reg, i_work_index[2:0]}; // RULE25
	end

	// ****************************************
	// Page select
	// ****************************************
	// Held until rewritten; no peripheral decode here, pages are decoded downstream
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			page_reg <= `PAGE_RESET;
		else if (i_set_page)
			page_reg <= i_instr_operand[5:0]; // RULE6
		else if (wr_page)
			page_reg <= i_reg_wdata[`PAGE_MSB:`PAGE_LSB]; // RULE6
	end

	// Page number to the group F decode
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_page_number <= `PAGE_RESET;
		else
			o_page_number <= page_reg; // RULE5
	end

	// ****************************************
	// Mode register
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			mode_reg <= `CORE_MODE_RESET; // RULE9
		else if (wr_mode)
			mode_reg <= i_reg_wdata;
	end

	assign sys_internal = mode_reg[`MODE_SYS_STACK_BIT];
	assign user_internal = mode_reg[`MODE_USER_STACK_BIT];

	// Registered copies of the stack placement
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_system_stack_internal <= 1'b1;
			o_user_stack_internal <= 1'b1;
		end
		else
		begin
			o_system_stack_internal <= sys_internal; // RULE10
			o_user_stack_internal <= user_internal; // RULE11
		end
	end

	// Internal clock from oscillator input, halve and prescale
	internal_clock_divider #(.PRESCALE_W(3)) u_clock_divider
	(
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.i_halve(mode_reg[`MODE_HALVE_BIT]),
		.i_prescale(mode_reg[`MODE_PRESCALE_MSB:`MODE_PRESCALE_LSB]),
		.o_tick(o_internal_clock_tick)
	);

	// ****************************************
	// External bus control
	// ****************************************
	// Request pin is asynchronous: two flops before use
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			bus_request_pin_meta_reg <= 1'b0;
			bus_request_pin_sync_reg <= 1'b0;
		end
		else
		begin
			bus_request_pin_meta_reg <= i_bus_request_pin;
			bus_request_pin_sync_reg <= bus_request_pin_meta_reg;
		end
	end

	// Request forwarded only while enabled
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			o_bus_request <= 1'b0;
		else
			o_bus_request <= bus_request_pin_sync_reg && mode_reg[`MODE_BUS_REQ_BIT]; // RULE14
	end

	// Float masks only bus lines; general I/O pins pass through
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_ext_addr_oe <= '0;
			o_ext_ctrl_oe <= '0;
			o_bus_float <= 1'b0;
		end
		else
		begin
			o_ext_addr_oe <= i_ext_addr_oe
				& ~({EXT_LINES{mode_reg[`MODE_FLOAT_BIT]}} & i_ext_is_bus); // RULE15 RULE16
			o_ext_ctrl_oe <= mode_reg[`MODE_FLOAT_BIT] ? '0 : i_ext_ctrl_oe; // RULE15
			o_bus_float <= mode_reg[`MODE_FLOAT_BIT];
		end
	end

	// ****************************************
	// Stack request arbitration
	// ****************************************
	// Requests seen while a push runs are dropped; the sequencer must wait on busy
	assign auto_any = i_interrupt_entry || i_call_segment || i_call_near;
	assign auto_go = (state_reg == ST_IDLE) && auto_any;
	assign push_go = (state_reg == ST_IDLE) && !auto_any && i_push;
	assign pop_go = (state_reg == ST_IDLE) && !auto_any && !i_push && i_pop;
	assign push_step = (state_reg == ST_PUSH);
	assign push_user = target_user_reg;

	// Pre-decremented addresses, low byte only in register file
	assign sys_dec = sys_ptr.ptr - 16'h0001;
	assign user_dec = user_ptr.ptr - 16'h0001;

	always_comb
	begin
		if (push_user)
			push_addr = user_internal ? {8'h00, user_dec[7:0]} : user_dec; // RULE22
		else
			push_addr = sys_internal ? {8'h00, sys_dec[7:0]} : sys_dec; // RULE22
		if (i_stack_user)
			pop_addr = user_internal ? {8'h00, user_ptr.ptr[7:0]} : user_ptr.ptr;
		else
			pop_addr = sys_internal ? {8'h00, sys_ptr.ptr[7:0]} : sys_ptr.ptr;
	end

	// Push sequencer state
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			state_reg <= ST_IDLE;
		else
		begin
			unique case (state_reg)
				ST_IDLE:
					if (auto_go || push_go)
						state_reg <= ST_PUSH;
				ST_PUSH:
					if (count_reg == 3'd1)
						state_reg <= ST_IDLE;
			endcase
		end
	end

	// Byte queue; page select is never part of it
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			queue_reg <= '0;
			count_reg <= 3'd0;
			target_user_reg <= 1'b0;
		end
		else if (auto_go)
		begin
			target_user_reg <= 1'b0;
			queue_reg <= {2'b00, i_code_segment, i_flags, i_pc[15:8], i_pc[7:0]}; // RULE8
			if (i_interrupt_entry)
			begin
				count_reg <= i_segment_push_enable ? 3'd4 : 3'd3; // RULE20
				queue_reg <= {2'b00, i_code_segment, i_flags, i_pc[15:8], i_pc[7:0]}; // RULE20
			end
			else if (i_call_segment)
			begin
				count_reg <= 3'd3; // RULE21
				queue_reg <= {10'h000, i_code_segment, i_pc[15:8], i_pc[7:0]}; // RULE21
			end
			else
				count_reg <= 3'd2; // RULE21
		end
		else if (push_go)
		begin
			target_user_reg <= i_stack_user;
			queue_reg <= {16'h0000, i_push_data};
			count_reg <= i_push_word ? 3'd2 : 3'd1; // RULE18
		end
		else if (push_step)
		begin
			queue_reg <= {8'h00, queue_reg[31:8]};
			count_reg <= count_reg - 3'd1;
		end
	end

	// ****************************************
	// Pointer unit control
	// ****************************************
	// A push step or pop beats a register load on the same pointer
	always_comb
	begin
		sys_ptr.step_down = push_step && !push_user; // RULE18
		sys_ptr.step_up = pop_go && !i_stack_user; // RULE18
		sys_ptr.step_two = i_pop_word;
		sys_ptr.internal = sys_internal; // RULE22
		sys_ptr.load_hi = i_reg_wr && (i_reg_addr == `OFS_SYS_SP_HI);
		sys_ptr.load_lo = i_reg_wr && (i_reg_addr == `OFS_SYS_SP_LO);
		sys_ptr.load_data = i_reg_wdata;
		user_ptr.step_down = push_step && push_user; // RULE18
		user_ptr.step_up = pop_go && i_stack_user; // RULE18
		user_ptr.step_two = i_pop_word;
		user_ptr.internal = user_internal; // RULE22
		user_ptr.load_hi = i_reg_wr && (i_reg_addr == `OFS_USER_SP_HI);
		user_ptr.load_lo = i_reg_wr && (i_reg_addr == `OFS_USER_SP_LO);
		user_ptr.load_data = i_reg_wdata;
	end

	stack_pointer_unit u_system_sp
	(
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.sp(sys_ptr)
	);

	stack_pointer_unit u_user_sp
	(
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.sp(user_ptr)
	);

	// ****************************************
	// Stack memory port
	// ****************************************
	// Pop reads only; nothing is written so old contents survive
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_stack_wr <= 1'b0;
			o_stack_rd <= 1'b0;
			o_stack_addr <= '0;
			o_stack_wdata <= 8'h00;
			o_stack_in_regfile <= 1'b1;
			o_stack_busy <= 1'b0;
		end
		else
		begin
			o_stack_wr <= push_step; // RULE18
			o_stack_rd <= pop_go; // RULE19
			o_stack_wdata <= queue_reg[7:0];
			if (push_step)
			begin
				o_stack_addr <= push_addr; // RULE18
				o_stack_in_regfile <= push_user ? user_internal : sys_internal;
			end
			else if (pop_go)
			begin
				o_stack_addr <= pop_addr; // RULE19
				o_stack_in_regfile <= i_stack_user ? user_internal : sys_internal;
			end
			o_stack_busy <= (auto_go || push_go) || (push_step && count_reg != 3'd1);
		end
	end

	// ****************************************
	// Register read
	// ****************************************
	always_comb
	begin
		read_hit = 1'b1;
		unique case (i_reg_addr)
			`OFS_FIRST_PTR: read_mux = {first_block_reg, pointer_mode_reg, 2'b00}; // RULE2
			`OFS_SECOND_PTR: read_mux = {second_block_reg, pointer_mode_reg, 2'b00}; // RULE2
			`OFS_PAGE_SELECT: read_mux = {page_reg, 2'b00}; // RULE7
			`OFS_CORE_MODE: read_mux = mode_reg;
			`OFS_USER_SP_HI: read_mux = user_ptr.ptr[15:8];
			`OFS_USER_SP_LO: read_mux = user_ptr.ptr[7:0];
			`OFS_SYS_SP_HI: read_mux = sys_ptr.ptr[15:8];
			`OFS_SYS_SP_LO: read_mux = sys_ptr.ptr[7:0];
			default:
			begin
				read_mux = 8'h00;
				read_hit = 1'b0;
			end
		endcase
	end

	// Read data one cycle after the strobe; unmapped reads give zero and no ack
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_reg_rdata <= 8'h00;
			o_reg_ack <= 1'b0;
		end
		else
		begin
			o_reg_rdata <= i_reg_rd ? read_mux : 8'h00;
			o_reg_ack <= i_reg_rd && read_hit;
		end
	end
endmodule

// ===== verif/sysreg_core_asserts.sv
// Purpose: port checks of the system register core
// Assumes: one clock, reset active low
// Notes: bound into every core instance
`timescale 1ns/1ps
module sysreg_core_asserts
#(
	parameter int EXT_LINES = 16,
	parameter int CTRL_LINES = 3
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_rstn,
	// Register and page side
	input wire logic o_reg_ack,
	input wire sysreg_pkg::reg_byte_t o_reg_rdata,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_set_page,
	input wire logic [7:0] i_instr_operand,
	input wire logic [5:0] o_page_number,
	// External bus
	input wire logic [EXT_LINES-1:0] i_ext_addr_oe,
	input wire logic [EXT_LINES-1:0] i_ext_is_bus,
	input wire logic [EXT_LINES-1:0] o_ext_addr_oe,
	input wire logic [CTRL_LINES-1:0] o_ext_ctrl_oe,
	input wire logic o_bus_float,
	input wire logic i_bus_request_pin,
	input wire logic o_bus_request,
	// Stack side
	input wire logic i_interrupt_entry,
	input wire logic i_call_segment,
	input wire logic i_segment_push_enable,
	input wire sysreg_pkg::sp_word_t i_pc,
	input wire logic [5:0] i_code_segment,
	input wire logic o_stack_busy,
	input wire logic o_stack_wr,
	input wire sysreg_pkg::sp_word_t o_stack_addr,
	input wire sysreg_pkg::reg_byte_t o_stack_wdata
);
	import sysreg_pkg::*;
	// ****
	// Checks
	// ****
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	property p_page_read;
		o_reg_ack && $past(i_reg_addr) == 8'hea |-> o_reg_rdata == {o_page_number, 2'b00};
	endproperty
	a_page_read: assert property (p_page_read) else $error("page read");
	property p_page_load;
		i_set_page |-> ##2 o_page_number == $past(i_instr_operand[5:0], 2);
	endproperty
	a_page_load: assert property (p_page_load) else $error("page load");
	// Masks hold once float has settled
	property p_float;
		o_bus_float && $past(o_bus_float) |-> o_ext_ctrl_oe == '0
			&& (o_ext_addr_oe & $past(i_ext_is_bus)) == '0;
	endproperty
	a_float: assert property (p_float) else $error("float mask");
	property p_io_lines;
		$past(i_rstn) |-> (o_ext_addr_oe & ~$past(i_ext_is_bus))
			== ($past(i_ext_addr_oe) & ~$past(i_ext_is_bus));
	endproperty
	a_io_lines: assert property (p_io_lines) else $error("io lines touched");
	property p_bus_request_pin;
		!i_bus_request_pin [*4] |=> !o_bus_request;
	endproperty
	a_bus_request_pin: assert property (p_bus_request_pin) else $error("bus request");
	property p_intr;
		i_interrupt_entry && !o_stack_busy && i_segment_push_enable |=> ##1 o_stack_wr [*3]
			##1 (o_stack_wr && o_stack_wdata == {2'b00, $past(i_code_segment, 5)});
	endproperty
	a_intr: assert property (p_intr) else $error("interrupt push");
	property p_seg;
		i_call_segment && !i_interrupt_entry && !o_stack_busy |=> ##1 o_stack_wr
			##1 (o_stack_wr && o_stack_wdata == $past(i_pc[15:8], 3));
	endproperty
	a_seg: assert property (p_seg) else $error("segment call push");
	property p_push_addr;
		o_stack_wr && $past(o_stack_wr) |-> o_stack_addr[7:0] == $past(o_stack_addr[7:0]) - 8'h1;
	endproperty
	a_push_addr: assert property (p_push_addr) else $error("push address");
endmodule

bind sysreg_core sysreg_core_asserts #(.EXT_LINES(EXT_LINES), .CTRL_LINES(CTRL_LINES))
	sysreg_core_asserts_i (.*);

// ===== verif/sysreg_core_tb.sv
// Purpose: self-checking bench of the system register core
// Assumes: 10 MHz clock, inputs move 1 ns after the rising edge
// Notes: expected values are worked out here, never read back
`timescale 1ns/1ps
module sysreg_core_tb;
	import sysreg_pkg::*;
	logic i_clk, i_rstn, i_reg_wr, i_reg_rd, i_set_single, i_set_first_pointer;
	logic i_set_second_pointer, i_set_page, i_push, i_push_word, i_pop, i_pop_word;
	logic i_stack_user, i_interrupt_entry, i_call_near, i_call_segment, i_segment_push_enable;
	logic i_bus_request_pin, o_reg_ack, o_stack_wr, o_stack_rd, o_stack_in_regfile;
	logic o_stack_busy, o_system_stack_internal, o_user_stack_internal, o_internal_clock_tick;
	logic o_bus_request, o_bus_float;
	logic [7:0] i_reg_addr, i_instr_operand, i_flags, o_work_addr, sp, v, b1, b2;
	logic [3:0] i_work_index;
	logic [5:0] i_code_segment, o_page_number;
	logic [15:0] i_ext_addr_oe, i_ext_is_bus, o_ext_addr_oe;
	logic [2:0] i_ext_ctrl_oe, o_ext_ctrl_oe;
	reg_byte_t i_reg_wdata, o_reg_rdata, o_stack_wdata;
	sp_word_t i_push_data, i_pc, o_stack_addr;
	int mismatches, tests_run;

	sysreg_core sysreg_core_i (.*);

	// Free-running 100 ns clock
	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_wr = 1'b1;
		tick(1);
		i_reg_wr = 1'b0;
		tick(1);
	endtask
	// Answer lands one edge after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic k);
		i_reg_addr = a;
		i_reg_rd = 1'b1;
		tick(1);
		i_reg_rd = 1'b0;
		chk(o_reg_rdata, e);
		chk(o_reg_ack, k);
		tick(1);
	endtask
	task automatic op(input logic [3:0] k, input logic [7:0] d);
		{i_set_single, i_set_first_pointer, i_set_second_pointer, i_set_page} = k;
		i_instr_operand = d;
		tick(1);
		{i_set_single, i_set_first_pointer, i_set_second_pointer, i_set_page} = 4'h0;
		tick(1);
	endtask
	// One stack request; follow each byte written, pointer steps down first
	task automatic stk(input logic [3:0] k, input logic [31:0] e, input int n);
		int c;
		c = 0;
		{i_interrupt_entry, i_call_segment, i_call_near, i_push} = k;
		tick(1);
		{i_interrupt_entry, i_call_segment, i_call_near, i_push} = 4'h0;
		repeat (6)
		begin
			if (o_stack_wr === 1'b1)
			begin
				sp = sp - 8'd1;
				chk(o_stack_addr, {8'h00, sp});
				chk(o_stack_wdata, e[8*c+:8]);
				chk(o_stack_in_regfile, 1'b1);
				c++;
			end
			tick(1);
		end
		chk(c, n);
	endtask
	// Period of the second gap, once settled
	task automatic per(input int f);
		int n;
		repeat (2)
		begin
			n = 0;
			do
			begin
				tick(1);
				n++;
			end
			while (o_internal_clock_tick !== 1'b1 && n < 40);
		end
		chk(n, f);
	endtask
	task automatic complete_run();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		{i_reg_wr, i_reg_rd, i_set_single, i_set_first_pointer, i_set_second_pointer, i_set_page,
			i_push, i_push_word, i_pop, i_pop_word, i_stack_user, i_interrupt_entry, i_call_near,
			i_call_segment, i_segment_push_enable, i_bus_request_pin, i_reg_addr, i_instr_operand,
			i_flags, i_work_index, i_code_segment, i_ext_addr_oe, i_ext_is_bus, i_ext_ctrl_oe,
			i_reg_wdata, i_push_data, i_pc} = '0;
		i_rstn = 1'b0;
		void'($urandom(32'hd28d));
		repeat (16) @(posedge i_clk);
		#1 i_rstn = 1'b1;
		rd(8'heb, 8'he0, 1'b1);
		chk(o_system_stack_internal, 1'b1);
		chk(o_user_stack_internal, 1'b1);
		rd(8'h10, 8'h00, 1'b0);
		repeat (8)
		begin
			v = 8'($urandom) | 8'h07;
			wr(8'he8, v);
			rd(8'he8, v & 8'hfc, 1'b1);
			b1 = 8'($urandom) & 8'h1f;
			b2 = 8'($urandom) & 8'h1f;
			i_work_index = 4'($urandom);
			op(4'h1, v);
			op(4'h8, b1);
			tick(1);
			chk(o_work_addr, {b1[4:1], i_work_index});
			rd(8'he8, {b1[4:0], 3'b000}, 1'b1);
			op(4'h4, b1);
			op(4'h2, b2);
			tick(1);
			chk(o_work_addr, {i_work_index[3] ? b2[4:0] : b1[4:0], i_work_index[2:0]});
			rd(8'he9, {b2[4:0], 3'b100}, 1'b1);
			rd(8'hea, {v[5:0], 2'b00}, 1'b1);
		end
		for (int p = 0; p < 8; p++)
		begin
			v = {p[2:1], p[0], p[2:0], 2'b00};
			wr(8'heb, v);
			rd(8'heb, v, 1'b1);
			chk(o_system_stack_internal, v[7]);
			chk(o_user_stack_internal, v[6]);
			per((p + 1) * (p[0] ? 2 : 1));
		end
		i_ext_addr_oe = 16'($urandom);
		i_ext_is_bus = 16'($urandom);
		i_ext_ctrl_oe = 3'h7;
		i_bus_request_pin = 1'b1;
		wr(8'heb, 8'he3);
		tick(4);
		chk(o_bus_request, 1'b1);
		chk(o_ext_ctrl_oe, 3'h0);
		chk(o_bus_float, 1'b1);
		chk(o_ext_addr_oe, i_ext_addr_oe & ~i_ext_is_bus);
		wr(8'heb, 8'he0);
		tick(4);
		chk(o_bus_request, 1'b0);
		chk(o_ext_addr_oe, i_ext_addr_oe);
		i_bus_request_pin = 1'b0;
		wr(8'hee, 8'h00);
		wr(8'hef, 8'h80);
		sp = 8'h80;
		i_pc = 16'($urandom);
		i_flags = 8'($urandom);
		i_code_segment = 6'($urandom);
		i_push_data = 16'($urandom);
		for (int s = 0; s < 2; s++)
		begin
			i_segment_push_enable = s[0];
			stk(4'h8, {2'b00, i_code_segment, i_flags, i_pc}, 3 + s);
		end
		stk(4'h4, {10'h000, i_code_segment, i_pc}, 3);
		stk(4'h2, {16'h0000, i_pc}, 2);
		i_push_word = 1'b1;
		stk(4'h1, {16'h0000, i_push_data}, 2);
		i_push_word = 1'b0;
		stk(4'h1, {16'h0000, i_push_data}, 1);
		rd(8'hee, 8'h00, 1'b1);
		i_pop_word = 1'b1;
		i_pop = 1'b1;
		tick(1);
		i_pop = 1'b0;
		chk({o_stack_rd, o_stack_wr}, 2'b10);
		chk(o_stack_addr, {8'h00, sp});
		tick(2);
		rd(8'hef, sp + 8'd2, 1'b1);
		complete_run();
	end

	// Hang guard
	initial
	begin
		#500000;
		mismatches++;
		complete_run();
	end
endmodule
